// ==== pus_pkg.sv ====
`default_nettype none
package pus_pkg;
   // -------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------
   localparam logic [6:0] FUNCTION_POWER_DOWN_ADDR = 7'h1e;
   localparam int PLL_DISABLE_BIT = 0;
   localparam int RECEIVER_DISABLE_BIT = 1;
   localparam int TRANSMITTER_DISABLE_BIT = 2;
   localparam int OSCILLATOR_DISABLE_BIT = 3;
   localparam int AUDIO_PORT_DISABLE_BIT = 4;
   localparam int ALL_OUTPUTS_HIZ_BIT = 5;
   localparam logic [5:0] PWR_RESET_SOFTWARE = 6'h07;
   localparam logic [5:0] PWR_RESET_HARDWARE = 6'h00;
   // -------------------------------------------------------------------
   // Two-wire bus addresses
   // -------------------------------------------------------------------
   localparam logic [6:0] DEV_ADDR_CSB_LOW = 7'h3a;
   localparam logic [6:0] DEV_ADDR_CSB_HIGH = 7'h3b;
   // -------------------------------------------------------------------
   // Input-hold timing
   // -------------------------------------------------------------------
   localparam longint HOLD_MIN_NS = 9400;
   localparam longint HOLD_MAX_NS = 25600;
   localparam longint XTAL_FAST_KHZ = 27000;
   localparam longint XTAL_SLOW_KHZ = 10000;
   localparam int HOLD_MIN_XTAL = int'((HOLD_MIN_NS * XTAL_FAST_KHZ + 999999) / 1000000);
   localparam int HOLD_MAX_XTAL = int'((HOLD_MAX_NS * XTAL_SLOW_KHZ) / 1000000);
   localparam int HOLD_XTAL_CYCLES = HOLD_MAX_XTAL;
   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   typedef enum logic {PUS_HOLD, PUS_RUN} pus_state_t;
   typedef struct packed {
      logic software_control_mode;
      logic three_wire_bus;
      logic [6:0] device_address;
      logic audio_port_master_select;
      logic [1:0] audio_port_format_straps;
      logic transmit_source_select;
   } pus_cfg_t;
   typedef struct packed {
      logic pll;
      logic receiver;
      logic transmitter;
      logic oscillator;
      logic audio_port;
   } pus_pwr_t;
   typedef struct packed {
      logic serial_data_in_pin;
      logic sclk;
      logic serial_data_out_pin;
      logic chip_select_pin;
      logic first_general_output_pin;
   } pus_pins_t;
endpackage : pus_pkg
`default_nettype wire

// ==== pus_powerup_strap_ctrl.sv ====
`default_nettype none
// Function
// - Configuration chosen from five sampled pin levels.
// - Pins held as inputs 9.4 to 25.6 us.
// - Hold length is fixed crystal cycle count.
// - Capture inside hold, then switch pin functions.
// - Software mode starts with bits 0-2 set, bits 3-5 clear.
// - Hardware mode powers everything up automatically.
// - Bits 0,1 disable PLL, receiver; reset 1.
// - Bit 2 disables transmitter; resets 1.
// - Bits 3,4 oscillator, audio port; reset 0.
// - Bit 5 tri-states all outputs; resets 0.
// - Hardware mode audio format from two straps.
// - Serial data low selects hardware mode.
// - General output low selects two-wire bus.
// - Chip select picks two-wire bus address.
module pus_powerup_strap_ctrl #(
   parameter int HOLD_CYCLES = pus_pkg::HOLD_XTAL_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic xtal_clk_pin,
   input var pus_pkg::pus_pins_t pin_in,
   output pus_pkg::pus_pins_t pin_out,
   output pus_pkg::pus_pins_t pin_oe,
   input wire logic reg_write_en,
   input wire logic reg_read_en,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_write_data,
   output logic [7:0] reg_read_data,
   input wire logic serial_data_in_pin_ack_drive,
   input wire logic serial_data_out_pin_data,
   input wire logic serial_data_out_pin_drive,
   input wire logic [2:0] gpo_value,
   input wire logic transmit_error_flag,
   input wire logic non_audio_flag,
   input wire logic unlock_flag,
   input wire logic general_flag_output,
   output logic config_done,
   output pus_pkg::pus_cfg_t cfg,
   output pus_pkg::pus_pwr_t pwr_enable,
   output logic all_outputs_hiz
);
   // -------------------------------------------------------------------
   // Elaboration check
   // -------------------------------------------------------------------
   if (HOLD_CYCLES < pus_pkg::HOLD_MIN_XTAL || HOLD_CYCLES > pus_pkg::HOLD_MAX_XTAL
       || HOLD_CYCLES > 65535) begin : g_bad_hold
      $error("HOLD_CYCLES outside the allowed input-hold window.");
   end

   localparam logic [15:0] HOLD_LAST = 16'(HOLD_CYCLES - 1);

   // -------------------------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------------------------
   logic [5:0] sync1, sync2, sync3, filt;
   logic [5:0] next_sync1, next_sync2, next_sync3, next_filt;
   logic xtal_rise;

   always_comb begin
      next_sync1 = {xtal_clk_pin, pin_in};
      next_sync2 = sync1;
      next_sync3 = sync2;
      next_filt = filt;
      if (sync2 == sync3) begin
         next_filt = sync3;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync1 <= 6'h00;
         sync2 <= 6'h00;
         sync3 <= 6'h00;
         filt <= 6'h00;
      end else begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
         sync3 <= next_sync3;
         filt <= next_filt;
      end
   end

   assign xtal_rise = (sync2[5] == sync3[5]) && sync3[5] && !filt[5];

   // -------------------------------------------------------------------
   // Hold sequencer, strap capture and power-down register
   // -------------------------------------------------------------------
   pus_pkg::pus_state_t state, next_state;
   logic [15:0] hold_count, next_hold_count;
   pus_pkg::pus_cfg_t next_cfg;
   logic [5:0] pwr_down, next_pwr_down;
   logic [7:0] next_reg_read_data;
   logic pwr_hit;
   pus_pkg::pus_pins_t st;

   assign st = filt[4:0];
   assign pwr_hit = reg_addr == pus_pkg::FUNCTION_POWER_DOWN_ADDR;

   always_comb begin
      next_state = state;
      next_hold_count = hold_count;
      next_cfg = cfg;
      next_pwr_down = pwr_down;
      next_reg_read_data = reg_read_data;
      case (state)
         pus_pkg::PUS_HOLD: begin
            if (xtal_rise) begin
               next_hold_count = hold_count + 16'h0001;
            end
            if (xtal_rise && hold_count == HOLD_LAST) begin
               next_state = pus_pkg::PUS_RUN;
               next_cfg.software_control_mode = st.serial_data_in_pin;
               next_cfg.three_wire_bus = st.serial_data_in_pin && st.first_general_output_pin;
               if (st.serial_data_in_pin && !st.first_general_output_pin && st.chip_select_pin) begin
                  next_cfg.device_address = pus_pkg::DEV_ADDR_CSB_HIGH;
               end else begin
                  next_cfg.device_address = pus_pkg::DEV_ADDR_CSB_LOW;
               end
               if (!st.serial_data_in_pin) begin
                  next_cfg.audio_port_master_select = st.sclk;
                  next_cfg.audio_port_format_straps = {st.first_general_output_pin, st.serial_data_out_pin};
                  next_cfg.transmit_source_select = st.chip_select_pin;
                  next_pwr_down = pus_pkg::PWR_RESET_HARDWARE;
               end else begin
                  next_cfg.audio_port_master_select = 1'b0;
                  next_cfg.audio_port_format_straps = 2'h0;
                  next_cfg.transmit_source_select = 1'b0;
                  next_pwr_down = pus_pkg::PWR_RESET_SOFTWARE;
               end
            end
         end
         pus_pkg::PUS_RUN: begin
            if (reg_write_en && pwr_hit && cfg.software_control_mode) begin
               next_pwr_down = reg_write_data[5:0];
            end
         end
         default: begin
            next_state = pus_pkg::PUS_HOLD;
         end
      endcase
      if (reg_read_en) begin
         if (pwr_hit) begin
            next_reg_read_data = {2'h0, pwr_down};
         end else begin
            next_reg_read_data = 8'h00;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= pus_pkg::PUS_HOLD;
         hold_count <= 16'h0000;
         cfg <= '0;
         pwr_down <= pus_pkg::PWR_RESET_SOFTWARE;
         reg_read_data <= 8'h00;
      end else begin
         state <= next_state;
         hold_count <= next_hold_count;
         cfg <= next_cfg;
         pwr_down <= next_pwr_down;
         reg_read_data <= next_reg_read_data;
      end
   end

   // -------------------------------------------------------------------
   // Function enables
   // -------------------------------------------------------------------
   logic run;

   assign run = state == pus_pkg::PUS_RUN;
   assign config_done = run;
   assign pwr_enable.pll = run && !pwr_down[pus_pkg::PLL_DISABLE_BIT];
   assign pwr_enable.receiver = run && !pwr_down[pus_pkg::RECEIVER_DISABLE_BIT];
   assign pwr_enable.transmitter = run && !pwr_down[pus_pkg::TRANSMITTER_DISABLE_BIT];
   assign pwr_enable.oscillator = run && !pwr_down[pus_pkg::OSCILLATOR_DISABLE_BIT];
   assign pwr_enable.audio_port = run && !pwr_down[pus_pkg::AUDIO_PORT_DISABLE_BIT];
   assign all_outputs_hiz = pwr_down[pus_pkg::ALL_OUTPUTS_HIZ_BIT];

   // -------------------------------------------------------------------
   // Pin function multiplexer
   // -------------------------------------------------------------------
   pus_pkg::pus_pins_t next_pin_out, next_pin_oe;

   always_comb begin
      next_pin_out = '0;
      next_pin_oe = '0;
      if (run && !cfg.software_control_mode) begin
         next_pin_out.sclk = transmit_error_flag;
         next_pin_out.serial_data_out_pin = non_audio_flag;
         next_pin_out.chip_select_pin = unlock_flag;
         next_pin_out.first_general_output_pin = general_flag_output;
         next_pin_oe = 5'h0f;
      end else if (run && cfg.three_wire_bus) begin
         next_pin_out.serial_data_out_pin = serial_data_out_pin_data;
         next_pin_oe.serial_data_out_pin = serial_data_out_pin_drive && !st.chip_select_pin;
         next_pin_out.first_general_output_pin = gpo_value[0];
         next_pin_oe.first_general_output_pin = 1'b1;
      end else if (run) begin
         next_pin_oe.serial_data_in_pin = serial_data_in_pin_ack_drive;
         next_pin_out.serial_data_out_pin = gpo_value[1];
         next_pin_out.chip_select_pin = gpo_value[2];
         next_pin_out.first_general_output_pin = gpo_value[0];
         next_pin_oe.serial_data_out_pin = 1'b1;
         next_pin_oe.chip_select_pin = 1'b1;
         next_pin_oe.first_general_output_pin = 1'b1;
      end
      if (pwr_down[pus_pkg::ALL_OUTPUTS_HIZ_BIT]) begin
         next_pin_oe = '0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pin_out <= '0;
         pin_oe <= '0;
      end else begin
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
      end
   end
endmodule : pus_powerup_strap_ctrl
`default_nettype wire

// ==== pus_strap_board.sv ====
`default_nettype none
module pus_strap_board (
   input wire pus_pkg::pus_pins_t strap,
   input wire pus_pkg::pus_pins_t pin_out,
   input wire pus_pkg::pus_pins_t pin_oe,
   output pus_pkg::pus_pins_t pin_in,
   output logic xtal
);
   timeunit 1ns;
   timeprecision 1ps;
   initial xtal = 1'b0;
   always #20 xtal = ~xtal;
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & strap);
endmodule : pus_strap_board
`default_nettype wire

// ==== pus_powerup_strap_ctrl_properties.sv ====
`default_nettype none
module pus_powerup_strap_ctrl_properties #(
   parameter int HOLD_CYCLES = 256
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic xtal_clk_pin,
   input wire pus_pkg::pus_pins_t pin_in,
   input wire pus_pkg::pus_pins_t pin_out,
   input wire pus_pkg::pus_pins_t pin_oe,
   input wire logic transmit_error_flag,
   input wire logic non_audio_flag,
   input wire logic unlock_flag,
   input wire logic general_flag_output,
   input wire logic config_done,
   input wire pus_pkg::pus_cfg_t cfg,
   input wire pus_pkg::pus_pwr_t pwr_enable,
   input wire logic all_outputs_hiz
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   logic xq;
   int xr;
   int next_xr;
   logic [3:0] flags;
   assign flags = {transmit_error_flag, non_audio_flag, unlock_flag, general_flag_output};
   always_comb begin
      next_xr = xr + int'(xtal_clk_pin && !xq && !config_done);
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         xq <= 1'b1;
         xr <= 0;
      end else begin
         xq <= xtal_clk_pin;
         xr <= next_xr;
      end
   end
   property p_hold; !config_done |-> pin_oe == 5'h00; endproperty
   a_hold: assert property (p_hold)
      else $error("pin driven before capture");
   property p_count; $rose(config_done) |-> xr >= HOLD_CYCLES - 1 && xr <= HOLD_CYCLES + 1;
   endproperty
   a_count: assert property (p_count)
      else $error("hold length wrong");
   property p_once; config_done |=> config_done && $stable(cfg); endproperty
   a_once: assert property (p_once)
      else $error("configuration changed");
   property p_pwr; $rose(config_done) |->
      pwr_enable == (cfg.software_control_mode ? 5'h03 : 5'h1f); endproperty
   a_pwr: assert property (p_pwr)
      else $error("power state at start wrong");
   property p_mode; $rose(config_done) |-> cfg.software_control_mode == pin_in.serial_data_in_pin
      && cfg.three_wire_bus == (pin_in.serial_data_in_pin && pin_in.first_general_output_pin); endproperty
   a_mode: assert property (p_mode)
      else $error("mode straps wrong");
   property p_addr; $rose(config_done) && pin_in.serial_data_in_pin && !pin_in.first_general_output_pin |->
      cfg.device_address == (pin_in.chip_select_pin ? 7'h3b : 7'h3a); endproperty
   a_addr: assert property (p_addr)
      else $error("bus address wrong");
   property p_hw; $rose(config_done) && !pin_in.serial_data_in_pin |->
      cfg.audio_port_master_select == pin_in.sclk && cfg.transmit_source_select == pin_in.chip_select_pin
      && cfg.audio_port_format_straps == {pin_in.first_general_output_pin, pin_in.serial_data_out_pin}; endproperty
   a_hw: assert property (p_hw)
      else $error("hardware straps wrong");
   property p_flags; config_done && !cfg.software_control_mode |=>
      pin_oe == 5'h0f && pin_out[3:0] == $past(flags); endproperty
   a_flags: assert property (p_flags)
      else $error("flag outputs wrong");
   property p_hiz; all_outputs_hiz |=> pin_oe == 5'h00; endproperty
   a_hiz: assert property (p_hiz)
      else $error("outputs not released");
endmodule : pus_powerup_strap_ctrl_properties
bind pus_powerup_strap_ctrl pus_powerup_strap_ctrl_properties #(.HOLD_CYCLES(HOLD_CYCLES))
   u_props (
   .clk(clk), .resetn(resetn), .xtal_clk_pin(xtal_clk_pin), .pin_in(pin_in),
   .pin_out(pin_out), .pin_oe(pin_oe), .transmit_error_flag(transmit_error_flag),
   .non_audio_flag(non_audio_flag), .unlock_flag(unlock_flag),
   .general_flag_output(general_flag_output), .config_done(config_done), .cfg(cfg),
   .pwr_enable(pwr_enable), .all_outputs_hiz(all_outputs_hiz));
`default_nettype wire

// ==== pus_powerup_strap_ctrl_test.sv ====
`default_nettype none
module pus_powerup_strap_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic xtal;
   logic we = 1'b0;
   logic re = 1'b0;
   logic [6:0] addr = 7'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic [3:0] flg = 4'h0;
   logic [2:0] gpv = 3'h5;
   logic ack = 1'b0;
   logic sdd = 1'b0;
   logic done;
   logic hiz;
   pus_pkg::pus_pins_t strap = 5'h00;
   pus_pkg::pus_pins_t pin_in;
   pus_pkg::pus_pins_t pin_out;
   pus_pkg::pus_pins_t pin_oe;
   pus_pkg::pus_cfg_t cfg;
   pus_pkg::pus_pwr_t pwr;
   int fails = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [4:0] st [4] = '{5'h0b, 5'h10, 5'h16, 5'h1d};
   logic [4:0] eo [4] = '{5'h0f, 5'h07, 5'h07, 5'h01};
   logic [4:0] eu [4] = '{5'h00, 5'h03, 5'h03, 5'h01};
   logic [4:0] eod [4] = '{5'h0f, 5'h17, 5'h17, 5'h05};
   logic [4:0] eud [4] = '{5'h00, 5'h03, 5'h03, 5'h05};
   logic [15:0] ec [4] = '{16'h03ad, 16'h13a0, 16'h13b0, 16'h1ba0};
   always #5 clk = ~clk;
   pus_strap_board u_board (.strap(strap), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_in(pin_in), .xtal(xtal));
   pus_powerup_strap_ctrl DUT (.clk(clk), .resetn(resetn), .xtal_clk_pin(xtal),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .reg_write_en(we),
      .reg_read_en(re), .reg_addr(addr), .reg_write_data(wdata), .reg_read_data(rdata),
      .serial_data_in_pin_ack_drive(ack), .serial_data_out_pin_data(sdd), .serial_data_out_pin_drive(sdd), .gpo_value(gpv),
      .transmit_error_flag(flg[3]), .non_audio_flag(flg[2]), .unlock_flag(flg[1]),
      .general_flag_output(flg[0]), .config_done(done), .cfg(cfg), .pwr_enable(pwr),
      .all_outputs_hiz(hiz));
   task automatic results();
      if (fails == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      we <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      we <= 1'b0;
      @(posedge clk);
      #1;
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [15:0] exp);
      @(posedge clk);
      re <= 1'b1;
      addr <= a;
      @(posedge clk);
      re <= 1'b0;
      #1;
      chk({8'h00, rdata}, exp);
   endtask : rd
   task automatic boot(input logic [4:0] s);
      @(posedge clk);
      resetn <= 1'b0;
      strap <= s;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      for (int k = 0; k < 3000 && done !== 1'b1; k++) @(posedge clk);
      #1;
   endtask : boot
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fails++;
         results();
      end
   end
   initial begin
      for (int i = 0; i < 4; i++) begin
         boot(st[i]);
         chk({15'h0000, done}, 16'h0001);
         chk(16'(cfg), ec[i]);
         chk(16'(pwr), (i == 0) ? 16'h001f : 16'h0003);
         chk(16'(pin_oe), 16'(eo[i]));
         chk(16'(pin_out), 16'(eu[i]));
         rd(7'h1e, (i == 0) ? 16'h0000 : 16'h0007);
         @(posedge clk);
         ack <= 1'b1;
         sdd <= 1'b1;
         repeat (2) @(posedge clk);
         #1;
         chk(16'(pin_oe), 16'(eod[i]));
         chk(16'(pin_out), 16'(eud[i]));
         @(posedge clk);
         ack <= 1'b0;
         sdd <= 1'b0;
      end
      wr(7'h1e, 8'h00);
      chk(16'(pwr), 16'h001f);
      wr(7'h1e, 8'h15);
      chk(16'(pwr), 16'h000a);
      wr(7'h1d, 8'hff);
      rd(7'h1e, 16'h0015);
      rd(7'h1d, 16'h0000);
      wr(7'h1e, 8'hff);
      chk({15'h0000, hiz}, 16'h0001);
      chk(16'(pin_oe), 16'h0000);
      rd(7'h1e, 16'h003f);
      boot(st[0]);
      @(posedge clk);
      flg <= 4'h6;
      repeat (2) @(posedge clk);
      #1;
      chk(16'(pin_oe), 16'h000f);
      chk({12'h000, pin_out[3:0]}, 16'h0006);
      wr(7'h1e, 8'h3f);
      rd(7'h1e, 16'h0000);
      chk(16'(pwr), 16'h001f);
      results();
   end
endmodule : pus_powerup_strap_ctrl_test
`default_nettype wire
